/* File: rtl/atsp_pkg.sv */
// Constants and types for the accelerometer/temperature serial port
package atsp_pkg;
	localparam int          CLK_HZ          = 50_000_000;
	localparam int          CONV_PERIOD_US  = 350;
	localparam int          CONV_TIME_US    = 25;
	localparam int          CONV_PERIOD_CYC = CONV_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int          CONV_TIME_CYC   = CONV_TIME_US * (CLK_HZ / 1_000_000);
	localparam int          FRAME_BITS      = 16;
	localparam int          CTRL_BITS       = 8;
	localparam int          TEMP_BITS       = 10;
	localparam int          ACC_BITS        = 12;
	localparam int          SAMPLE_EDGE     = 2;
	localparam int          AXIS_BIT        = 3;
	localparam int          PDOWN_BIT       = 0;
	localparam logic [7:0]  ACCEL_CTRL_RST  = 8'h04;
	localparam logic [9:0]  TEMP_RST        = 10'h000;
	typedef enum logic {ATSP_AXIS_X, ATSP_AXIS_Y} atsp_axis_t;
	typedef enum logic [1:0] {ATSP_T_IDLE, ATSP_T_CONV, ATSP_T_WAIT} atsp_tstate_t;
endpackage

/* File: rtl/atsp_shift.sv */
`timescale 1ns/1ps
// Serial-clock-domain frame engine for one chip select
module atsp_shift #(
	parameter int OUT_W = 16
) (
	input  wire logic             sclk,
	input  wire logic             sel_n,
	input  wire logic             din,
	input  wire logic [OUT_W-1:0] load_word,
	output logic                  dout,
	output logic                  dout_oe,
	output logic [7:0]            ctrl_word,
	output logic                  ctrl_tgl,
	output logic                  start_tgl,
	output logic                  sample_tgl,
	output logic [4:0]            edge_cnt
);
	import atsp_pkg::*;
	logic [OUT_W-1:0] sh_q;
	logic [7:0]       rx_q;
	logic [4:0]       cnt_q;

	// Rising edge: count and capture, restart every sixteen
	always_ff @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			cnt_q      <= 5'h00;
			rx_q       <= 8'h00;
		end else begin
			cnt_q <= (cnt_q == 5'(FRAME_BITS)) ? 5'h01 : cnt_q + 5'h01;
			rx_q  <= {rx_q[6:0], din};
		end
	end

	always_ff @(posedge sclk or posedge sel_n) begin
		if (sel_n) begin
			ctrl_word  <= ACCEL_CTRL_RST;
			ctrl_tgl   <= 1'b0;
			start_tgl  <= 1'b0;
			sample_tgl <= 1'b0;
		end else begin
			if (cnt_q == 5'(CTRL_BITS - 1)) begin
				ctrl_word <= {rx_q[6:0], din};
				ctrl_tgl  <= ~ctrl_tgl;
			end
			if (cnt_q == 5'(SAMPLE_EDGE - 1) || cnt_q == 5'(FRAME_BITS + SAMPLE_EDGE - 1))
				sample_tgl <= ~sample_tgl;
			if (cnt_q == 5'h00)
				start_tgl <= ~start_tgl;
		end
	end
	assign edge_cnt = cnt_q;

	// Falling edge: present next bit
	always_ff @(negedge sclk or posedge sel_n) begin
		if (sel_n) begin
			sh_q <= '0;
			dout <= 1'b0;
		end else begin
			if (cnt_q == 5'h01) begin
				dout <= load_word[OUT_W-1];
			end else if (cnt_q == 5'h02) begin
				// Word taken after the sample edge so it carries the new sample
				dout <= load_word[OUT_W-2];
				sh_q <= {load_word[OUT_W-3:0], 2'b00};
			end else if (cnt_q != 5'h00) begin
				dout <= sh_q[OUT_W-1];
				sh_q <= {sh_q[OUT_W-2:0], 1'b0};
			end
		end
	end
	assign dout_oe = ~sel_n;
endmodule

/* File: rtl/atsp_top.sv */
`timescale 1ns/1ps
// Serial port of a dual-axis acceleration sensor with temperature sensor
module atsp_top #(
	parameter int CONV_PERIOD = atsp_pkg::CONV_PERIOD_CYC,
	parameter int CONV_TIME   = atsp_pkg::CONV_TIME_CYC
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       sclk,
	input  wire logic       accel_select_n,
	input  wire logic       temp_select_n,
	input  wire logic       din,
	output logic            dout_o,
	output logic            dout_oe,
	input  wire logic [11:0] accel_x,
	input  wire logic [11:0] accel_y,
	input  wire logic [9:0] temp_sense,
	output logic            accel_powered_down,
	output logic            accel_axis_y,
	output logic            accel_sample,
	output logic            temp_converting,
	output logic            temp_lockout
);
	import atsp_pkg::*;

	// Accelerometer frame engine, clocked by serial clock
	logic        a_dout, a_oe, smp_tgl_q;
	logic [7:0]  a_ctrl;
	logic [4:0]  a_cnt;
	logic [15:0] a_load;
	logic [11:0] acc_q;
	logic [7:0]  accel_ctrl_q;
	logic        pdown_q, wake_pend_q;

	// Temperature frame engine, gated by its own select
	logic        t_sclk;
	logic        t_dout, t_oe;
	logic [15:0] t_load;
	logic [9:0]  t_snap_q;

	assign t_sclk = sclk & ~temp_select_n;

	// Axis data captured in the link domain on the sample edge
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			acc_q     <= 12'h000;
			smp_tgl_q <= 1'b0;
		end else if (!accel_select_n && a_cnt == 5'(SAMPLE_EDGE - 1) && !pdown_q) begin
			acc_q     <= accel_ctrl_q[AXIS_BIT] ? accel_y : accel_x;
			// Toggle survives deselect, so no false sample pulse follows a frame
			smp_tgl_q <= ~smp_tgl_q;
		end
	end
	assign a_load = {4'h0, acc_q};

	// Control word and power state live in the link domain
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			accel_ctrl_q <= ACCEL_CTRL_RST;
			pdown_q      <= 1'b0;
			wake_pend_q  <= 1'b0;
		end else if (!accel_select_n) begin
			// Engine holds the complete word from the eighth edge on
			if (a_cnt == 5'(CTRL_BITS)) begin
				accel_ctrl_q <= a_ctrl;
				if (a_ctrl[PDOWN_BIT])
					pdown_q <= 1'b1;
				else if (pdown_q)
					wake_pend_q <= 1'b1;
			end
			if (wake_pend_q && a_cnt == 5'(FRAME_BITS - 1)) begin
				pdown_q     <= 1'b0;
				wake_pend_q <= 1'b0;
			end
		end
	end

	atsp_shift #(.OUT_W(16)) u_accel (
		.sclk       (sclk),
		.sel_n      (accel_select_n),
		.din        (din),
		.load_word  (a_load),
		.dout       (a_dout),
		.dout_oe    (a_oe),
		.ctrl_word  (a_ctrl),
		.ctrl_tgl   (),
		.start_tgl  (),
		.sample_tgl (),
		.edge_cnt   (a_cnt)
	);

	// Leading zero, ten bits, then zeros
	assign t_load = {1'b0, t_snap_q, 5'h00};

	atsp_shift #(.OUT_W(16)) u_temp (
		.sclk       (t_sclk),
		.sel_n      (temp_select_n),
		.din        (din),
		.load_word  (t_load),
		.dout       (t_dout),
		.dout_oe    (t_oe),
		.ctrl_word  (),
		.ctrl_tgl   (),
		.start_tgl  (),
		.sample_tgl (),
		.edge_cnt   ()
	);

	// Only one select may be low at a time
	always_comb begin
		dout_o  = 1'b0;
		dout_oe = 1'b0;
		if (!accel_select_n) begin
			dout_o  = a_dout;
			dout_oe = a_oe;
		end else if (!temp_select_n) begin
			dout_o  = t_dout;
			dout_oe = t_oe;
		end
	end

	// Status of power and axis, synchronised into clk
	logic [1:0] pd_s, ax_s, smp_s;
	logic       smp_d_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pd_s    <= 2'b00;
			ax_s    <= 2'b00;
			smp_s   <= 2'b00;
			smp_d_q <= 1'b0;
		end else begin
			pd_s    <= {pd_s[0], pdown_q};
			ax_s    <= {ax_s[0], accel_ctrl_q[AXIS_BIT]};
			smp_s   <= {smp_s[0], smp_tgl_q};
			smp_d_q <= smp_s[1];
		end
	end
	assign accel_powered_down = pd_s[1];
	assign accel_axis_y       = ax_s[1];
	assign accel_sample       = smp_s[1] ^ smp_d_q;

	// Temperature select synchronised; its rise marks access end
	logic [1:0] tsel_s;
	logic       tsel_d_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tsel_s   <= 2'b11;
			tsel_d_q <= 1'b1;
		end else begin
			tsel_s   <= {tsel_s[0], temp_select_n};
			tsel_d_q <= tsel_s[1];
		end
	end
	logic access_fall, access_end;
	assign access_fall = tsel_d_q & ~tsel_s[1];
	assign access_end  = ~tsel_d_q & tsel_s[1];

	// Self-timed conversion sequencer
	atsp_tstate_t st_q;
	logic [31:0]  tmr_q;
	logic [9:0]   result_q;
	logic         lock_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q  <= ATSP_T_WAIT;
			tmr_q <= 32'h0;
		end else if (access_end) begin
			st_q  <= ATSP_T_CONV;
			tmr_q <= 32'h0;
		end else begin
			unique case (st_q)
				ATSP_T_IDLE: begin
					st_q  <= ATSP_T_CONV;
					tmr_q <= 32'h0;
				end
				ATSP_T_CONV: begin
					if (tmr_q >= 32'(CONV_TIME - 1)) begin
						st_q  <= ATSP_T_WAIT;
						tmr_q <= 32'h0;
					end else
						tmr_q <= tmr_q + 32'h1;
				end
				ATSP_T_WAIT: begin
					if (tmr_q >= 32'(CONV_PERIOD - 1)) begin
						st_q  <= ATSP_T_IDLE;
						tmr_q <= 32'h0;
					end else
						tmr_q <= tmr_q + 32'h1;
				end
			endcase
		end
	end

	// Lockout set by access during conversion, cleared in IDLE before the next timed start, not on an access-end restart
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= 1'b0;
		end else if (st_q == ATSP_T_CONV && (access_fall || !tsel_s[1])) begin
			lock_q <= 1'b1;
		end else if (st_q == ATSP_T_IDLE) begin
			lock_q <= 1'b0;
		end
	end

	// Result register updates only at end of an unlocked conversion
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			result_q <= TEMP_RST;
		end else if (st_q == ATSP_T_CONV && tmr_q >= 32'(CONV_TIME - 1) && !lock_q) begin
			result_q <= temp_sense;
		end
	end

	// Snapshot held stable across a frame; idle select lets it follow
	logic [9:0] res_hold_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			res_hold_q <= TEMP_RST;
		else if (tsel_s[1] && tsel_d_q)
			res_hold_q <= result_q;
	end
	always_ff @(negedge temp_select_n or negedge nrst) begin
		if (!nrst)
			t_snap_q <= TEMP_RST;
		else
			t_snap_q <= res_hold_q;
	end

	assign temp_converting = (st_q == ATSP_T_CONV);
	assign temp_lockout    = lock_q;
endmodule

/* File: dv/atsp_host.sv */
// Host model: frames transfers with its own serial clock
`timescale 1ns/1ps
module atsp_host (
	output logic      sclk,
	output logic      sel_acc_n,
	output logic      sel_tmp_n,
	output logic      din,
	input  wire logic dout
);
	initial begin
		sclk = 1'b0;
		sel_acc_n = 1'b1;
		sel_tmp_n = 1'b1;
		din = 1'b0;
	end
	// Clock stands low outside frames; nf frames under one select, 48 ns period
	task automatic xfer(input logic acc, input logic [7:0] w, input int nf,
		output logic [31:0] rx);
		rx = '0;
		#7;
		sel_acc_n = !acc;
		sel_tmp_n = acc;
		for (int i = 0; i < 16 * nf; i++) begin
			din = (i % 16 < 8) ? w[7 - i % 16] : 1'b0;
			#12 sclk = 1'b1;
			#24 sclk = 1'b0;
			#12 rx = {rx[30:0], dout};
		end
		sel_acc_n = 1'b1;
		sel_tmp_n = 1'b1;
		#100;
	endtask
endmodule

/* File: dv/atsp_top_assertions.sv */
// Port checks of the serial port top
`timescale 1ns/1ps
module atsp_chk #(
	parameter int CONV_PERIOD = 200,
	parameter int CONV_TIME   = 20
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic accel_select_n,
	input wire logic temp_select_n,
	input wire logic dout_oe,
	input wire logic accel_powered_down,
	input wire logic accel_sample,
	input wire logic temp_converting,
	input wire logic temp_lockout
);
	logic [15:0] conv_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) conv_q <= '0;
		else conv_q <= temp_converting ? conv_q + 16'h1 : '0;
	end
	property p_oe_off;
		$rose(accel_select_n & temp_select_n) |-> ##[0:4] !dout_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe held");
	property p_oe_on;
		$fell(accel_select_n) |-> ##[0:3] dout_oe;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe missing");
	property p_smp;
		$fell(accel_select_n) && !accel_powered_down |-> ##[1:12] accel_sample;
	endproperty
	a_smp: assert property (p_smp) else $error("no sample");
	property p_idle;
		accel_select_n && $past(accel_select_n, 6) |-> !accel_sample;
	endproperty
	a_idle: assert property (p_idle) else $error("idle sample");
	property p_conv;
		$fell(temp_converting) |-> conv_q == CONV_TIME;
	endproperty
	a_conv: assert property (p_conv) else $error("bad conv time");
	property p_lk_set;
		!$past(temp_select_n, 3) && !temp_select_n && temp_converting |-> ##[0:2] temp_lockout;
	endproperty
	a_lk_set: assert property (p_lk_set) else $error("no lockout");
	property p_lk_clr;
		$rose(temp_converting) && temp_select_n && $past(temp_select_n, 4) |-> ##[1:2] !temp_lockout;
	endproperty
	a_lk_clr: assert property (p_lk_clr) else $error("lockout stuck");
	property p_pd;
		accel_select_n && $past(accel_select_n, 6) |-> $stable(accel_powered_down);
	endproperty
	a_pd: assert property (p_pd) else $error("mode moved");
	c_smp: cover property (accel_sample);
	c_lk: cover property ($rose(temp_lockout));
	c_pd: cover property ($rose(accel_powered_down));
endmodule
bind atsp_top atsp_chk #(.CONV_PERIOD(CONV_PERIOD), .CONV_TIME(CONV_TIME)) i_chk (
	.clk(clk), .nrst(nrst), .accel_select_n(accel_select_n), .temp_select_n(temp_select_n),
	.dout_oe(dout_oe), .accel_powered_down(accel_powered_down), .accel_sample(accel_sample),
	.temp_converting(temp_converting), .temp_lockout(temp_lockout));

/* File: dv/atsp_top_bench.sv */
// Bench for the serial port: host frames and result checks
`timescale 1ns/1ps
module atsp_top_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, acc_n, tmp_n, din, dout_o, dout_oe, pd, axis_y, lock;
	logic [11:0] ax = 12'habc;
	logic [11:0] ay = 12'h123;
	logic [9:0] ts = '0;
	logic [9:0] tv [3] = '{10'h3ff, 10'h001, 10'h360};
	logic [31:0] rx;
	int error_cnt = 0;
	int checks_done = 0;
	always #10 clk = ~clk;
	atsp_top #(.CONV_PERIOD(200), .CONV_TIME(20)) i_dut (.clk(clk), .nrst(nrst), .sclk(sclk),
		.accel_select_n(acc_n), .temp_select_n(tmp_n), .din(din), .dout_o(dout_o),
		.dout_oe(dout_oe), .accel_x(ax), .accel_y(ay), .temp_sense(ts),
		.accel_powered_down(pd), .accel_axis_y(axis_y), .accel_sample(),
		.temp_converting(), .temp_lockout(lock));
	atsp_host i_host (.sclk(sclk), .sel_acc_n(acc_n), .sel_tmp_n(tmp_n), .din(din),
		.dout(dout_o));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		error_cnt++;
		results();
	end
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (500) @(posedge clk);
		i_host.xfer(1'b1, 8'h0c, 1, rx);
		chk(rx[15:0], {4'h0, ax});
		chk({15'h0, dout_oe}, 16'h0);
		repeat (8) @(posedge clk);
		chk({15'h0, axis_y}, 16'h1);
		i_host.xfer(1'b1, 8'h0d, 1, rx);
		chk(rx[15:0], {4'h0, ay});
		repeat (8) @(posedge clk);
		chk({14'h0, pd, axis_y}, 16'h3);
		i_host.xfer(1'b1, 8'h0c, 1, rx);
		repeat (8) @(posedge clk);
		chk({15'h0, pd}, 16'h0);
		i_host.xfer(1'b1, 8'h84, 1, rx);
		chk(rx[15:0], {4'h0, ay});
		i_host.xfer(1'b1, 8'h04, 1, rx);
		chk(rx[15:0], {4'h0, ax});
		// Select held for two frames: second frame uses the new axis
		i_host.xfer(1'b1, 8'h0c, 2, rx);
		chk(rx[31:16], {4'h0, ax});
		chk(rx[15:0], {4'h0, ay});
		i_host.xfer(1'b0, 8'h00, 1, rx);
		foreach (tv[i]) begin
			@(posedge clk);
			ts <= tv[i];
			repeat (500) @(posedge clk);
			i_host.xfer(1'b0, 8'h00, 1, rx);
			chk(rx[15:0], {1'b0, tv[i], 5'h0});
		end
		@(posedge clk);
		ts <= 10'h155;
		repeat (4) @(posedge clk);
		i_host.xfer(1'b0, 8'h00, 1, rx);
		chk(rx[15:0], {1'b0, tv[2], 5'h0});
		chk({15'h0, dout_oe}, 16'h0);
		chk({15'h0, lock}, 16'h1);
		results();
	end
endmodule
